// >>> hdl/dar_pkg.sv
// Constants and types of the drawing address register bank
// What this block does
// - Source address is 24 bits, signed or unsigned
// - Polyline uses source address without software setup
// - Source address is always linear pixel address
// - Page bits 26:24 extend source to 27 bits
// - Engine updates never touch the page bits
// - Page bits used only for monochrome blit
// - Page bits ignored for trapezoid and lines
// - Right-edge error is 18-bit two's complement
// - Error register unused for line and blit
// - Polyline end loads x start with x end
// - Signed pitch sign selects source scan direction for blit
// - Polyline start uses y start, reloaded displacement
// - Polyline end loads y start with y end
// - Trapezoid takes major increment from y register
// - Background colour feeds colour expansion source
// - Background width follows pixel depth, block mode
// - Plane mask per bit, width follows depth at 8 and 16 bpp, full 32 bits at 24 and 32 bpp
// - Only whole-word writes via queue accepted
// - Writes pass the queue before the engine
// - Source write also loads line start address
package dar_pkg;
   // Register byte offsets
   localparam logic [15:0] OFS_BACKGROUND_COLOR = 16'h1c20;
   localparam logic [15:0] OFS_SOURCE_CURRENT_ADDRESS = 16'h1c6c;
   localparam logic [15:0] OFS_RIGHT_EDGE_ERROR = 16'h1c70;
   localparam logic [15:0] OFS_X_START_OR_PITCH = 16'h1c74;
   localparam logic [15:0] OFS_Y_START_OR_MAJOR_INCREMENT = 16'h1c78;
   localparam logic [15:0] OFS_BLIT_PLANE_MASK = 16'h1c28;
   // Field layout
   localparam int SRC_W = 24;
   localparam int PAGE_LSB = 24;
   localparam int PAGE_W = 3;
   localparam int FLD18_W = 18;
   localparam int PAT_W = 27;
   // Byte enables of a full word
   localparam logic [3:0] BE_WORD = 4'hf;
   // Bus write queue depth and pointer widths
   localparam int QUEUE_DEPTH = 4;
   localparam int QPTR_W = 2;
   localparam int QCNT_W = 3;
   localparam logic [QCNT_W-1:0] QUEUE_FULL = 3'h4;
   // Reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // Drawing operation codes
   typedef enum logic [2:0] {
      OP_LINE = 3'b000,
      OP_POLYLINE = 3'b001,
      OP_TRAP = 3'b010,
      OP_BLIT = 3'b011,
      OP_IMAGE_LOAD = 3'b100
   } dar_op_t;
   // Pixel depth codes
   typedef enum logic [1:0] {
      BPP_8 = 2'b00,
      BPP_16 = 2'b01,
      BPP_24 = 2'b10,
      BPP_32 = 2'b11
   } dar_bpp_t;
endpackage

// >>> hdl/dar_regs.sv
// Drawing address register bank with its bus write queue
`timescale 1ns/10ps
`default_nettype none
module dar_regs
   import dar_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic WR_REQ,
   input wire logic [15:0] WR_ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic [3:0] WR_BE,
   output logic WR_READY,
   input wire logic ENG_HOLD,
   input wire logic [2:0] OP_MODE,
   input wire logic SRC_MONO,
   input wire logic [1:0] PIX_DEPTH,
   input wire logic BLOCK_MODE,
   input wire logic ALU_SRC_WE,
   input wire logic [23:0] ALU_SRC_DATA,
   input wire logic ALU_ERR_WE,
   input wire logic [17:0] ALU_ERR_DATA,
   input wire logic ALU_YDISP_WE,
   input wire logic [17:0] ALU_YDISP_DATA,
   input wire logic POLYLINE_END,
   input wire logic [17:0] X_END,
   input wire logic [17:0] Y_END,
   output logic [26:0] SRC_ADDR,
   output logic [31:0] SRC_ADDR_EXT,
   output logic [23:0] LINE_START_ADDR,
   output logic [23:0] ERR_EXT,
   output logic [23:0] PITCH_EXT,
   output logic [23:0] YREG_EXT,
   output logic SCAN_UP,
   output logic [31:0] BG_PIXEL,
   output logic [31:0] PLANE_MASK
);
   ////////////////////////////////////////////////////////////////////////////////
   // Bus write queue
   logic [15:0] q_addr [QUEUE_DEPTH]; // Queued addresses
   logic [31:0] q_data [QUEUE_DEPTH]; // Queued data words
   logic [QPTR_W-1:0] wp_q; // Write pointer
   logic [QPTR_W-1:0] rp_q; // Read pointer
   logic [QCNT_W-1:0] cnt_q; // Entries held
   logic [QCNT_W-1:0] cnt_d;
   logic ready_q; // Room for one more word
   wire push = WR_REQ && ready_q && (WR_BE == BE_WORD); // Whole words only
   wire pop = (cnt_q != '0) && !ENG_HOLD; // Engine takes one word per cycle
   wire [15:0] pop_addr = q_addr[rp_q];
   wire [31:0] pop_data = q_data[rp_q];

   // Count update
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 3'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 3'h1;
      end
   end

   // Queue storage
   always_ff @(posedge MCLK) begin
      if (push) begin
         q_addr[wp_q] <= WR_ADDR;
         q_data[wp_q] <= WR_DATA;
      end
   end

   // Queue pointers and ready flag
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wp_q <= push ? wp_q + 2'h1 : wp_q;
         rp_q <= pop ? rp_q + 2'h1 : rp_q;
         cnt_q <= cnt_d;
         ready_q <= (cnt_d != QUEUE_FULL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode, only queued words reach the registers
   wire wr_bg = pop && (pop_addr == OFS_BACKGROUND_COLOR);
   wire wr_src = pop && (pop_addr == OFS_SOURCE_CURRENT_ADDRESS);
   wire wr_err = pop && (pop_addr == OFS_RIGHT_EDGE_ERROR);
   wire wr_x = pop && (pop_addr == OFS_X_START_OR_PITCH);
   wire wr_y = pop && (pop_addr == OFS_Y_START_OR_MAJOR_INCREMENT);
   wire wr_msk = pop && (pop_addr == OFS_BLIT_PLANE_MASK);
   wire op_auto = (OP_MODE == OP_POLYLINE);
   wire op_blit = (OP_MODE == OP_BLIT);
   wire op_line = (OP_MODE == OP_LINE);
   wire op_trap = (OP_MODE == OP_TRAP);

   logic [23:0] src_q; // Source current address
   logic [2:0] page_q; // Source page extension
   logic [23:0] lsrc_q; // Line start source address
   logic [17:0] err_q; // Right-edge error term
   logic [17:0] xreg_q; // X start or pitch
   logic [17:0] yreg_q; // Y start or major increment
   logic [31:0] bg_q; // Background colour
   logic [31:0] msk_q; // Blit plane mask

   ////////////////////////////////////////////////////////////////////////////////
   // Source address and page; host writes win over engine updates
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         src_q <= '0;
         page_q <= '0;
         lsrc_q <= '0;
      end else if (wr_src) begin
         src_q <= pop_data[SRC_W-1:0];
         page_q <= pop_data[PAGE_LSB+PAGE_W-1:PAGE_LSB];
         lsrc_q <= pop_data[SRC_W-1:0];
      end else if (ALU_SRC_WE) begin
         src_q <= ALU_SRC_DATA; // Page kept
      end
   end

   // Right-edge error term, internal in polyline
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         err_q <= '0;
      end else if (wr_err) begin
         err_q <= pop_data[FLD18_W-1:0];
      end else if (ALU_ERR_WE && op_auto) begin
         err_q <= ALU_ERR_DATA;
      end
   end

   // X start or pitch
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         xreg_q <= '0;
      end else if (wr_x) begin
         xreg_q <= pop_data[FLD18_W-1:0];
      end else if (POLYLINE_END && op_auto) begin
         xreg_q <= X_END;
      end
   end

   // Y start, displacement or major increment
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         yreg_q <= '0;
      end else if (wr_y) begin
         yreg_q <= pop_data[FLD18_W-1:0];
      end else if (POLYLINE_END && op_auto) begin
         yreg_q <= Y_END;
      end else if (ALU_YDISP_WE && op_auto) begin
         yreg_q <= ALU_YDISP_DATA;
      end
   end

   // Colour registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         bg_q <= RESET_WORD;
         msk_q <= RESET_WORD;
      end else begin
         bg_q <= wr_bg ? pop_data : bg_q;
         msk_q <= wr_msk ? pop_data : msk_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operand shaping toward the engine
   wire page_use = op_blit && SRC_MONO;
   wire [2:0] page_eff = page_use ? page_q : 3'h0;
   wire src_sign = (op_auto || op_line || op_trap) ? src_q[SRC_W-1] : 1'b0;
   wire [23:0] err_sx = {{(SRC_W-FLD18_W){err_q[FLD18_W-1]}}, err_q};
   wire [23:0] x_sx = {{(SRC_W-FLD18_W){xreg_q[FLD18_W-1]}}, xreg_q};
   wire [23:0] y_sx = {{(SRC_W-FLD18_W){yreg_q[FLD18_W-1]}}, yreg_q};
   wire err_used = !(op_line || op_blit);
   wire pitch_neg = xreg_q[FLD18_W-1]; // Negative source pitch
   logic [31:0] bg_eff;
   logic [31:0] msk_eff;

   // Pixel depth selects the live colour bits
   always_comb begin
      bg_eff = bg_q;
      msk_eff = msk_q;
      unique case (PIX_DEPTH)
         BPP_8: begin
            bg_eff = {24'h00_0000, bg_q[7:0]};
            msk_eff = {24'h00_0000, msk_q[7:0]};
         end
         BPP_16: begin
            bg_eff = {16'h0000, bg_q[15:0]};
            msk_eff = {16'h0000, msk_q[15:0]};
         end
         BPP_24: begin
            bg_eff = BLOCK_MODE ? bg_q : {8'h00, bg_q[23:0]};
         end
         BPP_32: begin
            bg_eff = bg_q;
         end
      endcase
   end

   // Output flops
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         SRC_ADDR <= '0;
         SRC_ADDR_EXT <= '0;
         LINE_START_ADDR <= '0;
         ERR_EXT <= '0;
         PITCH_EXT <= '0;
         YREG_EXT <= '0;
         SCAN_UP <= 1'b0;
         BG_PIXEL <= RESET_WORD;
         PLANE_MASK <= RESET_WORD;
      end else begin
         SRC_ADDR <= {page_eff, src_q}; // Linear address
         SRC_ADDR_EXT <= {{8{src_sign}}, src_q};
         LINE_START_ADDR <= lsrc_q;
         ERR_EXT <= err_used ? err_sx : 24'h00_0000;
         PITCH_EXT <= x_sx;
         YREG_EXT <= y_sx;
         SCAN_UP <= op_blit && pitch_neg; // Bottom to top
         BG_PIXEL <= bg_eff;
         PLANE_MASK <= msk_eff;
      end
   end

   assign WR_READY = ready_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   property p_line_start_follows;
      wr_src |=> (lsrc_q == 24'($past(pop_data))) ##1 (LINE_START_ADDR == $past(lsrc_q));
   endproperty
   a_line_start_follows: assert property (p_line_start_follows) else $error("line start not loaded");

   property p_page_kept;
      (ALU_SRC_WE && !wr_src) |=> $stable(page_q) && (src_q == $past(ALU_SRC_DATA));
   endproperty
   a_page_kept: assert property (p_page_kept) else $error("page bits changed by engine");

   property p_auto_end;
      (POLYLINE_END && op_auto && !wr_x && !wr_y) |=>
         (xreg_q == $past(X_END)) && (yreg_q == $past(Y_END));
   endproperty
   a_auto_end: assert property (p_auto_end) else $error("polyline end not loaded");

   property p_page_gate;
      !page_use |=> (SRC_ADDR[26:24] == 3'h0);
   endproperty
   a_page_gate: assert property (p_page_gate) else $error("page used outside mono blit");

   property p_scan_dir;
      op_blit |=> (SCAN_UP == $past(pitch_neg));
   endproperty
   a_scan_dir: assert property (p_scan_dir) else $error("scan direction wrong");

   property p_bg_8bpp;
      (PIX_DEPTH == BPP_8) |=> (BG_PIXEL == (32'h0000_00ff & $past(bg_q)));
   endproperty
   a_bg_8bpp: assert property (p_bg_8bpp) else $error("background width wrong");

   property p_mask_16bpp;
      (PIX_DEPTH == BPP_16) |=> (PLANE_MASK == (32'h0000_ffff & $past(msk_q)));
   endproperty
   a_mask_16bpp: assert property (p_mask_16bpp) else $error("plane mask width wrong");

   property p_err_unused;
      (op_line || op_blit) |=> (ERR_EXT == 24'h00_0000);
   endproperty
   a_err_unused: assert property (p_err_unused) else $error("error term leaked");

   // Engine error updates are refused outside polyline
   property p_err_hold;
      (ALU_ERR_WE && !op_auto && !wr_err) |=> $stable(err_q);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error term moved");

   property p_sign_ext;
      ##1 (PITCH_EXT[23:17] == {7{PITCH_EXT[17]}}) && (ERR_EXT[23:17] == {7{ERR_EXT[17]}});
   endproperty
   a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

   property p_queue_full;
      (cnt_q == QUEUE_FULL) |-> !WR_READY ##1 (cnt_q <= QUEUE_FULL);
   endproperty
   a_queue_full: assert property (p_queue_full) else $error("queue overrun");

   property p_partial_refused;
      (WR_REQ && ready_q && (WR_BE != BE_WORD) && !pop) |=> (cnt_q == $past(cnt_q));
   endproperty
   a_partial_refused: assert property (p_partial_refused) else $error("partial write taken");

   c_fill: cover property (cnt_q == QUEUE_FULL);
   c_src_write: cover property (wr_src ##2 LINE_START_ADDR != 24'h00_0000);
   c_auto_end: cover property (POLYLINE_END && op_auto);
   c_mono_page: cover property (SRC_ADDR[26:24] != 3'h0);
endmodule
`default_nettype wire

// >>> dv/dar_host.sv
// Host model that writes drawing registers through the write queue
`timescale 1ns/10ps
`default_nettype none
module dar_host (
   input wire logic clk,
   input wire logic ready,
   output logic req,
   output logic [15:0] addr,
   output logic [31:0] data,
   output logic [3:0] be
);
   // Idle bus at time zero
   initial begin
      req = 1'b0;
      addr = 16'h0;
      data = 32'h0;
      be = 4'h0;
   end
   // One write, held until ready is seen at an edge, then released
   task automatic put(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic ok);
      logic r;
      ok = 1'b0;
      @(posedge clk);
      req <= 1'b1;
      addr <= a;
      data <= d;
      be <= b;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(negedge clk) r = ready;
         @(posedge clk);
         ok = (r === 1'b1);
      end
      // Released address and data lines no longer show the last value
      req <= 1'b0;
      addr <= ~a;
      data <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> dv/drawing_address_registers_bench.sv
// Testbench of the drawing address register bank
`timescale 1ns/10ps
`default_nettype none
module drawing_address_registers_bench;
   import dar_pkg::*;
   logic mclk, rst_n, wr_req, wr_ready, eng_hold, src_mono, block_mode, scan_up;
   logic alu_src_we, alu_err_we, alu_ydisp_we, polyline_end;
   logic [15:0] wr_addr;
   logic [31:0] wr_data, src_addr_ext, bg_pixel, plane_mask;
   logic [3:0] wr_be;
   logic [2:0] op_mode;
   logic [1:0] pix_depth;
   logic [23:0] alu_src_data, line_start_addr, err_ext, pitch_ext, yreg_ext;
   logic [17:0] alu_err_data, alu_ydisp_data, x_end, y_end;
   logic [26:0] src_addr;
   int bad_count = 0;
   int num_checks = 0;
   dar_host host_u (.clk(mclk), .ready(wr_ready), .req(wr_req), .addr(wr_addr),
      .data(wr_data), .be(wr_be));
   dar_regs dut_u (.MCLK(mclk), .RST_N(rst_n), .WR_REQ(wr_req), .WR_ADDR(wr_addr),
      .WR_DATA(wr_data), .WR_BE(wr_be), .WR_READY(wr_ready), .ENG_HOLD(eng_hold),
      .OP_MODE(op_mode), .SRC_MONO(src_mono), .PIX_DEPTH(pix_depth),
      .BLOCK_MODE(block_mode), .ALU_SRC_WE(alu_src_we), .ALU_SRC_DATA(alu_src_data),
      .ALU_ERR_WE(alu_err_we), .ALU_ERR_DATA(alu_err_data), .ALU_YDISP_WE(alu_ydisp_we),
      .ALU_YDISP_DATA(alu_ydisp_data), .POLYLINE_END(polyline_end), .X_END(x_end),
      .Y_END(y_end), .SRC_ADDR(src_addr), .SRC_ADDR_EXT(src_addr_ext),
      .LINE_START_ADDR(line_start_addr), .ERR_EXT(err_ext), .PITCH_EXT(pitch_ext),
      .YREG_EXT(yreg_ext), .SCAN_UP(scan_up), .BG_PIXEL(bg_pixel), .PLANE_MASK(plane_mask));
   // 100 ns clock
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and shared helpers
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Output lag of a queued write, then sample between edges
   task automatic settle();
      repeat (5) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
      logic ok;
      host_u.put(a, d, b, ok);
      if (ok !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask
   task automatic mode(input logic [2:0] op, input logic mono);
      @(posedge mclk);
      op_mode <= op;
      src_mono <= mono;
      settle();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_src();
      logic [2:0] op;
      wr(OFS_SOURCE_CURRENT_ADDRESS, 32'h0580_0001, BE_WORD);
      for (int m = 0; m < 6; m++) begin
         op = 3'(m < 5 ? m : 3);
         mode(op, m != 5);
         chk(32'(src_addr), {5'h0, (op == OP_BLIT && m != 5) ? 3'h5 : 3'h0, 24'h800001});
         chk(src_addr_ext, op <= OP_TRAP ? 32'hff80_0001 : 32'h0080_0001);
      end
      chk(32'(line_start_addr), 32'h0080_0001);
      mode(OP_BLIT, 1'b1);
      @(posedge mclk);
      alu_src_we <= 1'b1;
      alu_src_data <= 24'h000123;
      @(posedge mclk);
      alu_src_we <= 1'b0;
      settle();
      chk(32'(src_addr), 32'h0500_0123);
      $display("test src done");
   endtask
   task automatic test_err();
      wr(OFS_RIGHT_EDGE_ERROR, 32'h0002_0001, BE_WORD);
      mode(OP_TRAP, 1'b0);
      chk(32'(err_ext), 32'h00fe_0001);
      @(posedge mclk);
      alu_err_we <= 1'b1;
      alu_err_data <= 18'h00005;
      @(posedge mclk);
      alu_err_we <= 1'b0;
      settle();
      chk(32'(err_ext), 32'h00fe_0001);
      mode(OP_LINE, 1'b0);
      chk(32'(err_ext), 32'h0);
      mode(OP_BLIT, 1'b0);
      chk(32'(err_ext), 32'h0);
      wr(OFS_X_START_OR_PITCH, 32'h0003_fffe, BE_WORD);
      settle();
      chk({7'h00, scan_up, pitch_ext}, 32'h01ff_fffe);
      wr(OFS_X_START_OR_PITCH, 32'h0000_0002, BE_WORD);
      settle();
      chk({7'h00, scan_up, pitch_ext}, 32'h0000_0002);
      mode(OP_POLYLINE, 1'b0);
      @(posedge mclk);
      alu_err_we <= 1'b1;
      alu_err_data <= 18'h00005;
      @(posedge mclk);
      alu_err_we <= 1'b0;
      settle();
      chk(32'(err_ext), 32'h5);
      $display("test err done");
   endtask
   task automatic test_poly();
      wr(OFS_Y_START_OR_MAJOR_INCREMENT, 32'h0000_0010, BE_WORD);
      settle();
      chk(32'(yreg_ext), 32'h10);
      @(posedge mclk);
      alu_ydisp_we <= 1'b1;
      alu_ydisp_data <= 18'h3ffff;
      @(posedge mclk);
      alu_ydisp_we <= 1'b0;
      polyline_end <= 1'b1;
      x_end <= 18'h00111;
      y_end <= 18'h3fff0;
      @(negedge mclk);
      @(negedge mclk);
      chk(32'(yreg_ext), 32'h00ff_ffff);
      @(posedge mclk);
      polyline_end <= 1'b0;
      settle();
      chk({pitch_ext, yreg_ext[7:0]}, 32'h0001_11f0);
      mode(OP_TRAP, 1'b0);
      wr(OFS_Y_START_OR_MAJOR_INCREMENT, 32'h0000_0042, BE_WORD);
      settle();
      chk(32'(yreg_ext), 32'h42);
      $display("test poly done");
   endtask
   task automatic test_color();
      logic [31:0] bg_exp [5] = '{32'h11, 32'h2211, 32'h44_2211, 32'h8844_2211, 32'h8844_2211};
      logic [31:0] mk_exp [5] = '{32'hf0, 32'hf0f0, 32'hf0f0_f0f0, 32'hf0f0_f0f0, 32'hf0f0_f0f0};
      wr(OFS_BACKGROUND_COLOR, 32'h8844_2211, BE_WORD);
      wr(OFS_BLIT_PLANE_MASK, 32'hf0f0_f0f0, BE_WORD);
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk);
         pix_depth <= 2'(k < 4 ? k : 2);
         block_mode <= (k == 4);
         settle();
         chk(bg_pixel, bg_exp[k]);
         chk(plane_mask, mk_exp[k]);
      end
      $display("test color done");
   endtask
   task automatic test_queue();
      @(posedge mclk);
      eng_hold <= 1'b1;
      wr(16'h1c40, 32'h0000_0007, BE_WORD);
      wr(OFS_BACKGROUND_COLOR, 32'h1, BE_WORD);
      wr(OFS_BACKGROUND_COLOR, 32'h2, BE_WORD);
      wr(OFS_BACKGROUND_COLOR, 32'hc3c3_c3c3, BE_WORD);
      settle();
      chk({31'h0, wr_ready}, 32'h0);
      chk(bg_pixel, 32'h8844_2211);
      @(posedge mclk);
      eng_hold <= 1'b0;
      settle();
      settle();
      chk({bg_pixel[30:0], wr_ready}, {32'h8787_8787 | 32'h1});
      wr(OFS_BACKGROUND_COLOR, 32'h0, 4'h3);
      settle();
      chk(bg_pixel, 32'hc3c3_c3c3);
      $display("test queue done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {mclk, rst_n, eng_hold, src_mono, block_mode, alu_src_we, alu_err_we} = 7'h0;
      {alu_ydisp_we, polyline_end, op_mode, pix_depth} = 7'h0;
      {alu_src_data, alu_err_data, alu_ydisp_data, x_end, y_end} = 96'h0;
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      chk({wr_ready, 4'h0, src_addr}, 32'h0);
      @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk({31'h0, wr_ready}, 32'h1);
      test_src();
      test_err();
      test_poly();
      test_color();
      test_queue();
      end_of_test();
   end
endmodule
`default_nettype wire
